/* File: src/smsp_top.sv */
// two-wire slave port with two memory windows, page write and timed programming
`timescale 1ns/10ps
`default_nettype none
`include "smsp_defines.svh"
module smsp_top #(
  parameter int NV_PROGRAM_CYC = (`SMSP_NV_PROGRAM_TIME_NS + `SMSP_CLK_NS - 1) / `SMSP_CLK_NS,
  parameter int FRAME_CYC      = `SMSP_FRAME_NS / `SMSP_CLK_NS
) (
  input  wire logic        clock_i,                 // system clock, 100 MHz
  input  wire logic        srst_i,                  // synchronous reset, active high
  input  wire logic        bus_sample_clk_i,        // link clock that samples the bus pins
  input  wire logic        scl_i,                   // serial clock pin level
  input  wire logic        sda_i,                   // serial data pin level
  output logic             sda_o,                   // serial data drive value
  output logic             sda_oe_o,                // serial data drive enable
  input  wire logic        analog_poweron_level_i,  // supply above analog power-on level
  input  wire logic        digital_poweron_level_i, // supply above digital power-on level
  input  wire logic [15:0] temp_i,                  // temperature converter result
  input  wire logic        supply_low_i,            // supply converter below alarm limit
  input  wire logic        main_write_protect_i,    // main window is write protected
  input  wire logic        aux_write_protect_i,     // secondary window is write protected
  output logic             standby_o,               // port in low-power standby
  output logic             nv_busy_o,               // programming cycle running
  output logic             not_ready_flag_o,        // active-low ready flag
  output logic             supply_low_alarm_o       // supply-low alarm flag
);
  import smsp_pkg::*;

  smsp_link_t r;          // link domain state
  smsp_link_t next_r;     // its next value
  smsp_sys_t  s;          // system domain state
  smsp_sys_t  next_s;     // its next value
  logic [1:0] link_rst_sy; // reset carried into the link domain
  logic       link_rst;   // link domain reset
  logic [7:0] mem_main [0:255]; // main window storage
  logic [7:0] mem_aux  [0:255]; // secondary window storage
  logic       sclr;       // filtered clock rising
  logic       sclf;       // filtered clock falling
  logic       start_ev;   // start seen
  logic       stop_ev;    // stop seen
  logic       commit_now; // page goes to storage this cycle
  logic       upd_now;    // conversion results arrive this cycle
  logic [7:0] main_addr;  // slave address of main window
  logic [7:0] rd_byte;    // byte at the current location
  logic       wp_now;     // addressed window protected

  // reset crosses with two flops; the link clock never sees srst_i directly
  always_ff @(posedge bus_sample_clk_i)
  begin
    link_rst_sy <= {link_rst_sy[0], srst_i};
  end
  assign link_rst = link_rst_sy[1];

  // main window address: default until recalled and configured
  always_comb
  begin
    main_addr = `SMSP_DEF_ADDR;
    if (r.rcl_sy[1] && (mem_main[`SMSP_CFG_LOC] != `SMSP_UNCFG))
    begin
      main_addr = mem_main[`SMSP_CFG_LOC];
    end
    rd_byte = r.win ? mem_aux[r.loc] : mem_main[r.loc];
    wp_now  = r.win ? r.wpa_sy[1] : r.wpm_sy[1];
  end

  // bus events from the filtered pin levels
  assign sclr       = r.scl_f & ~r.scl_p;
  assign sclf       = ~r.scl_f & r.scl_p;
  assign start_ev   = r.scl_f & r.scl_p & r.sda_p & ~r.sda_f;
  assign stop_ev    = r.scl_f & r.scl_p & ~r.sda_p & r.sda_f;
  assign commit_now = stop_ev & ~r.busy & (r.pmask != 8'h00);
  assign upd_now    = r.upd_sy[1] != r.upd_p;

  // link protocol engine
  always_comb
  begin
    next_r = r;
    // three-flop pin sampling; a change counts when flops two and three agree
    next_r.scl_sy = {r.scl_sy[1:0], scl_i};
    next_r.sda_sy = {r.sda_sy[1:0], sda_i};
    if (r.scl_sy[1] == r.scl_sy[2])
    begin
      next_r.scl_f = r.scl_sy[2];
    end
    if (r.sda_sy[1] == r.sda_sy[2])
    begin
      next_r.sda_f = r.sda_sy[2];
    end
    next_r.scl_p = r.scl_f;
    next_r.sda_p = r.sda_f;
    // level and event crossings from the system side and the write protect pins
    next_r.done_sy = {r.done_sy[0], s.done_tog};
    next_r.done_p  = r.done_sy[1];
    next_r.upd_sy  = {r.upd_sy[0], s.upd_tog};
    next_r.upd_p   = r.upd_sy[1];
    next_r.rcl_sy  = {r.rcl_sy[0], s.recalled};
    next_r.wpm_sy  = {r.wpm_sy[0], main_write_protect_i};
    next_r.wpa_sy  = {r.wpa_sy[0], aux_write_protect_i};
    if (upd_now)
    begin
      next_r.upd_ack = r.upd_sy[1]; // hand the toggle back once stored
    end
    if (r.done_sy[1] != r.done_p)
    begin
      next_r.busy = 1'b0; // programming finished
    end
    if (r.busy)
    begin
      // inputs ignored while programming; no acknowledge for polling
      next_r.st     = SMSP_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else if (start_ev)
    begin
      // a repeated start drops any uncommitted page
      next_r.st     = SMSP_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.pmask  = 8'h00;
    end
    else if (stop_ev)
    begin
      next_r.st     = SMSP_IDLE;
      next_r.sda_oe = 1'b0;
      if (commit_now)
      begin
        next_r.busy       = 1'b1;
        next_r.commit_tog = ~r.commit_tog;
        next_r.pmask      = 8'h00;
      end
    end
    else
    begin
      case (r.st)
        SMSP_ADDR, SMSP_WLOC, SMSP_WDATA:
        begin
          // receive: sample on the rising clock, decide after the eighth bit
          if (sclr && (r.bitcnt != `SMSP_BYTE_BITS))
          begin
            next_r.shreg  = {r.shreg[6:0], r.sda_f};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
          else if (sclf && (r.bitcnt == `SMSP_BYTE_BITS))
          begin
            next_r.bitcnt = 4'h0;
            next_r.st     = SMSP_ACK;
            next_r.sda_oe = 1'b1;
            if (r.st == SMSP_ADDR)
            begin
              next_r.rd = r.shreg[0];
              if ({r.shreg[7:1], 1'b0} == `SMSP_AUX_ADDR)
              begin
                next_r.win = 1'b1;
              end
              else if ({r.shreg[7:1], 1'b0} == main_addr)
              begin
                next_r.win = 1'b0;
              end
              else
              begin
                next_r.st     = SMSP_IDLE;
                next_r.sda_oe = 1'b0;
              end
              next_r.after = r.shreg[0] ? SMSP_RDATA : SMSP_WLOC;
            end
            else if (r.st == SMSP_WLOC)
            begin
              next_r.loc   = r.shreg;
              next_r.after = SMSP_WDATA;
            end
            else if (wp_now)
            begin
              // protected window: no write mode, nothing stored
              next_r.st     = SMSP_IDLE;
              next_r.sda_oe = 1'b0;
            end
            else
            begin
              // page buffer holds the last eight bytes of this page
              next_r.pdata[{r.loc[2:0], 3'b000} +: 8] = r.shreg;
              next_r.pmask[r.loc[2:0]] = 1'b1;
              next_r.pbase = r.loc[7:3];
              next_r.pwin  = r.win;
              next_r.loc   = {r.loc[7:3], r.loc[2:0] + 3'h1};
              next_r.after = SMSP_WDATA;
            end
          end
        end
        SMSP_ACK:
        begin
          // release after the ninth pulse, or put out the first read bit
          if (sclf)
          begin
            next_r.st     = r.after;
            next_r.sda_oe = 1'b0;
            if (r.after == SMSP_RDATA)
            begin
              next_r.shreg  = rd_byte;
              next_r.sda_oe = ~rd_byte[7];
              next_r.bitcnt = 4'h1;
            end
          end
        end
        SMSP_RDATA:
        begin
          // transmit: change data only after the clock falls
          if (sclf && (r.bitcnt == `SMSP_BYTE_BITS))
          begin
            next_r.sda_oe = 1'b0;
            next_r.st     = SMSP_RACK;
            next_r.loc    = r.loc + 8'h01;
          end
          else if (sclf)
          begin
            next_r.shreg  = {r.shreg[6:0], 1'b0};
            next_r.sda_oe = ~r.shreg[6];
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        SMSP_RACK:
        begin
          // master acknowledge asks for the next byte
          if (sclr)
          begin
            next_r.mack = ~r.sda_f;
          end
          else if (sclf && r.mack)
          begin
            next_r.st     = SMSP_RDATA;
            next_r.shreg  = rd_byte;
            next_r.sda_oe = ~rd_byte[7];
            next_r.bitcnt = 4'h1;
          end
          else if (sclf)
          begin
            next_r.st = SMSP_IDLE; // line left high for the stop
          end
        end
        default:
        begin
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
    next_r.sda_out = 1'b0;
    next_r.standby = (next_r.st == SMSP_IDLE) & ~next_r.busy;
  end

  // link state register
  always_ff @(posedge bus_sample_clk_i)
  begin
    if (link_rst)
    begin
      r         <= '0;
      r.scl_sy  <= 3'h7;
      r.sda_sy  <= 3'h7;
      r.scl_f   <= 1'b1;
      r.sda_f   <= 1'b1;
      r.scl_p   <= 1'b1;
      r.sda_p   <= 1'b1;
      r.st      <= SMSP_IDLE;
      r.after   <= SMSP_IDLE;
      r.standby <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // storage: reset stands for a blank part; page commit, then result bytes
  always_ff @(posedge bus_sample_clk_i)
  begin
    if (link_rst)
    begin
      for (int i = 0; i < 256; i++)
      begin
        mem_main[i] <= `SMSP_BLANK;
        mem_aux[i]  <= `SMSP_BLANK;
      end
    end
    else
    begin
      if (commit_now)
      begin
        for (int i = 0; i < 8; i++)
        begin
          if (r.pmask[i] && r.pwin)
          begin
            mem_aux[{r.pbase, 3'(i)}] <= r.pdata[i*8 +: 8];
          end
          else if (r.pmask[i])
          begin
            mem_main[{r.pbase, 3'(i)}] <= r.pdata[i*8 +: 8];
          end
        end
      end
      if (upd_now)
      begin
        // system side holds these stable until the toggle comes back
        mem_main[`SMSP_TEMP_MSB_LOC] <= s.conv.temp[15:8];
        mem_main[`SMSP_TEMP_LSB_LOC] <= s.conv.temp[7:0];
        mem_main[`SMSP_RDY_LOC][`SMSP_RDY_BIT]   <= s.conv.not_ready;
        mem_main[`SMSP_ALARM_LOC][`SMSP_VLO_BIT] <= s.conv.vlow;
      end
    end
  end

  // system side: power levels, conversions and the programming timer
  always_comb
  begin
    next_s = s;
    next_s.pa_sy  = {s.pa_sy[1:0], analog_poweron_level_i};
    next_s.pd_sy  = {s.pd_sy[1:0], digital_poweron_level_i};
    if (s.pa_sy[1] == s.pa_sy[2])
    begin
      next_s.pa_f = s.pa_sy[2];
    end
    if (s.pd_sy[1] == s.pd_sy[2])
    begin
      next_s.pd_f = s.pd_sy[2];
    end
    next_s.cmt_sy = {s.cmt_sy[0], r.commit_tog};
    next_s.cmt_p  = s.cmt_sy[1];
    next_s.act_sy = {s.act_sy[0], ~r.standby};
    next_s.ack_sy = {s.ack_sy[0], r.upd_ack};
    // settings recalled above the analog level, lost below the digital one
    if (!s.pd_f)
    begin
      next_s.recalled = 1'b0;
    end
    else if (s.pa_f)
    begin
      next_s.recalled = 1'b1;
    end
    // programming cycle started by each committed page
    if (s.cmt_sy[1] != s.cmt_p)
    begin
      next_s.nv_busy  = 1'b1;
      next_s.prog_cnt = 32'h0;
    end
    else if (s.nv_busy && (s.prog_cnt >= 32'(NV_PROGRAM_CYC - 1)))
    begin
      next_s.nv_busy  = 1'b0;
      next_s.done_tog = ~s.done_tog;
    end
    else if (s.nv_busy)
    begin
      next_s.prog_cnt = s.prog_cnt + 32'h1;
    end
    // conversion frame; the count waits at its end while the bus is in use
    if (!s.pa_f)
    begin
      next_s.frame_cnt      = 32'h0;
      next_s.conv.not_ready = 1'b1;
      next_s.upd_pend       = next_s.upd_pend | ~s.conv.not_ready;
    end
    else if (s.frame_cnt < 32'(FRAME_CYC - 1))
    begin
      next_s.frame_cnt = s.frame_cnt + 32'h1;
    end
    else if (!s.act_sy[1])
    begin
      // new conversion only between accesses
      next_s.frame_cnt      = 32'h0;
      next_s.conv.temp      = temp_i;
      next_s.conv.vlow      = supply_low_i;
      next_s.conv.not_ready = 1'b0;
      next_s.upd_pend       = 1'b1;
    end
    // one result in flight at a time so the link reads stable data
    if (next_s.upd_pend && (s.ack_sy[1] == s.upd_tog))
    begin
      next_s.upd_tog  = ~s.upd_tog;
      next_s.upd_pend = 1'b0;
    end
  end

  // system state register
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      s                <= '0;
      s.conv.not_ready <= 1'b1;
      s.conv.vlow      <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign sda_o              = r.sda_out;
  assign sda_oe_o           = r.sda_oe;
  assign standby_o          = r.standby;
  assign nv_busy_o          = s.nv_busy;
  assign not_ready_flag_o   = s.conv.not_ready;
  assign supply_low_alarm_o = s.conv.vlow;
endmodule
`default_nettype wire

/* File: src/smsp_defines.svh */
// constants of the serial memory slave port: addresses, locations, bits, times
`ifndef SMSP_DEFINES_SVH
`define SMSP_DEFINES_SVH
`define SMSP_DEF_ADDR      8'hA2
`define SMSP_AUX_ADDR      8'hA0
`define SMSP_UNCFG         8'hFF
`define SMSP_BLANK         8'hFF
`define SMSP_CFG_LOC       8'h8C
`define SMSP_TEMP_MSB_LOC  8'h60
`define SMSP_TEMP_LSB_LOC  8'h61
`define SMSP_RDY_LOC       8'h6E
`define SMSP_RDY_BIT       0
`define SMSP_ALARM_LOC     8'h70
`define SMSP_VLO_BIT       4
`define SMSP_BYTE_BITS     4'h8
`define SMSP_CLK_NS        10
`define SMSP_NV_PROGRAM_TIME_NS 10000000
`define SMSP_FRAME_NS      1000000
`endif

/* File: src/smsp_pkg.sv */
// types of the serial memory slave port
package smsp_pkg;
  // protocol states of the link side
  typedef enum logic [2:0] {
    SMSP_IDLE  = 3'b000,
    SMSP_ADDR  = 3'b001,
    SMSP_WLOC  = 3'b010,
    SMSP_WDATA = 3'b011,
    SMSP_ACK   = 3'b100,
    SMSP_RDATA = 3'b101,
    SMSP_RACK  = 3'b110
  } smsp_st_t;

  // conversion results handed from system side to link side
  typedef struct packed {
    logic [15:0] temp;
    logic        not_ready;
    logic        vlow;
  } smsp_conv_t;

  // whole state of the link domain
  typedef struct packed {
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_f;
    logic        sda_f;
    logic        scl_p;
    logic        sda_p;
    smsp_st_t    st;
    smsp_st_t    after;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        win;
    logic        rd;
    logic        mack;
    logic [7:0]  loc;
    logic [63:0] pdata;
    logic [7:0]  pmask;
    logic [4:0]  pbase;
    logic        pwin;
    logic        busy;
    logic        commit_tog;
    logic [1:0]  done_sy;
    logic        done_p;
    logic [1:0]  upd_sy;
    logic        upd_p;
    logic        upd_ack;
    logic [1:0]  rcl_sy;
    logic [1:0]  wpm_sy;
    logic [1:0]  wpa_sy;
    logic        sda_oe;
    logic        sda_out;
    logic        standby;
  } smsp_link_t;

  // whole state of the system domain
  typedef struct packed {
    logic [2:0]  pa_sy;
    logic [2:0]  pd_sy;
    logic        pa_f;
    logic        pd_f;
    logic        recalled;
    logic [31:0] frame_cnt;
    logic [31:0] prog_cnt;
    logic [1:0]  cmt_sy;
    logic        cmt_p;
    logic        nv_busy;
    logic        done_tog;
    logic [1:0]  act_sy;
    logic [1:0]  ack_sy;
    logic        upd_tog;
    logic        upd_pend;
    smsp_conv_t  conv;
  } smsp_sys_t;
endpackage

/* File: tb/smsp_master.sv */
// two-wire bus master model that drives serial clock and data
`timescale 1ns/10ps
`default_nettype none
module smsp_master #(
  parameter int Q = 25                // quarter bit in system clocks
) (
  input  wire logic clock_i,          // paces the bus timing
  input  wire logic sda_i,            // resolved data wire
  output logic      scl_o,            // serial clock, high while idle
  output logic      sda_low_o         // 1 pulls data low
);
  // bus idle: both lines left high
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // quarter bits, counted off the falling edge of clock_i
  task automatic hold(input int n);
    repeat (n * Q) @(negedge clock_i);
  endtask
  // start, or repeated start from a low clock
  task automatic start();
    if (!scl_o)
    begin
      sda_low_o = 1'b0;
      hold(1);
      scl_o = 1'b1;
      hold(2);
    end
    sda_low_o = 1'b1;
    hold(2);
    scl_o = 1'b0;
    hold(1);
  endtask
  // stop: data rises while clock is high
  task automatic stop();
    sda_low_o = 1'b1;
    hold(1);
    scl_o = 1'b1;
    hold(2);
    sda_low_o = 1'b0;
    hold(2);
  endtask
  // data moves a quarter after the clock fall, so it never races it
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    hold(1);
    scl_o = 1'b1;
    hold(1);
    r = sda_i;
    hold(1);
    scl_o = 1'b0;
    hold(1);
  endtask
  // byte out msb first, then the ninth clock for the answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in; acknowledge asks for more, no acknowledge ends the read
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/smsp_top_sva.sv */
// checker of the two-wire slave port, bound to its top
`timescale 1ns/10ps
`default_nettype none
module smsp_top_sva #(
  parameter int NV_PROGRAM_CYC = 50,  // programming length
  parameter int FRAME_CYC      = 200  // conversion frame
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic bus_sample_clk_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic analog_poweron_level_i,
  input wire logic standby_o,
  input wire logic nv_busy_o,
  input wire logic not_ready_flag_o,
  input wire logic supply_low_alarm_o
);
  logic [31:0] busy_cnt;              // clocks of the running programming
  logic [2:0]  lrst_sy;               // reset as the link side still sees it
  // the link side leaves reset some link edges after srst_i falls
  always_ff @(posedge bus_sample_clk_i)
  begin
    lrst_sy <= {lrst_sy[1:0], srst_i};
  end
  // count while programming, so its length can be judged at the end
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !nv_busy_o)
      busy_cnt <= '0;
    else
      busy_cnt <= busy_cnt + 32'h1;
  end
  property p_edge;
    @(posedge bus_sample_clk_i) disable iff (srst_i || (lrst_sy != 3'h0))
      $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_edge: assert property (p_edge) else $error("data drive moved with clock high");
  property p_low;
    @(posedge bus_sample_clk_i) disable iff (srst_i || (lrst_sy != 3'h0))
      sda_oe_o |-> !sda_o && !standby_o;
  endproperty
  a_low: assert property (p_low) else $error("driven data not low");
  property p_quiet;
    @(posedge clock_i) disable iff (srst_i) nv_busy_o |-> !sda_oe_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer while programming");
  property p_len;
    @(posedge clock_i) disable iff (srst_i)
      $fell(nv_busy_o) |-> busy_cnt >= NV_PROGRAM_CYC && busy_cnt <= NV_PROGRAM_CYC + 1;
  endproperty
  a_len: assert property (p_len) else $error("programming length wrong");
  property p_sleep;
    @(posedge clock_i) disable iff (srst_i) $fell(nv_busy_o) |-> ##[1:60] standby_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no standby after programming");
  property p_flags;
    @(posedge clock_i) disable iff (srst_i)
      $fell(srst_i) |-> supply_low_alarm_o && not_ready_flag_o && !nv_busy_o;
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong after reset");
  property p_drop;
    @(posedge clock_i) disable iff (srst_i)
      $fell(analog_poweron_level_i) |-> ##[1:8] not_ready_flag_o;
  endproperty
  a_drop: assert property (p_drop) else $error("ready flag kept below level");
  property p_ready;
    @(posedge clock_i) disable iff (srst_i) $fell(not_ready_flag_o) |-> analog_poweron_level_i;
  endproperty
  a_ready: assert property (p_ready) else $error("ready without supply");
  c_prog: cover property (@(posedge clock_i) $rose(nv_busy_o));
  c_ready: cover property (@(posedge clock_i) $fell(not_ready_flag_o));
  c_ack: cover property (@(posedge bus_sample_clk_i) $rose(sda_oe_o));
endmodule
bind smsp_top smsp_top_sva #(.NV_PROGRAM_CYC(NV_PROGRAM_CYC), .FRAME_CYC(FRAME_CYC))
  u_smsp_top_sva (.clock_i(clock_i), .srst_i(srst_i), .bus_sample_clk_i(bus_sample_clk_i),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_o(standby_o),
  .analog_poweron_level_i(analog_poweron_level_i), .nv_busy_o(nv_busy_o),
  .not_ready_flag_o(not_ready_flag_o), .supply_low_alarm_o(supply_low_alarm_o));
`default_nettype wire

/* File: tb/tb_serial_memory_slave_port.sv */
// self-checking bench of the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
module tb_serial_memory_slave_port;
  localparam int NV_CYC = 1500;       // long enough to poll inside it
  localparam int FRM = 200;           // short conversion frame
  logic        clock_i, srst_i, lclk; // clocks and reset
  logic        scl, m_low;            // master side of the bus
  logic        sda_o, sda_oe_o;       // port side of the data wire
  logic        ana, dig, vlow, wpm, wpa;
  logic [15:0] temp;
  logic        stby, busy, nrdy, alarm;
  int          err_count, checks;
  wire         sda = !((sda_oe_o && !sda_o) || m_low); // pulled up when released
  smsp_top #(.NV_PROGRAM_CYC(NV_CYC), .FRAME_CYC(FRM)) u_smsp_top (
    .clock_i(clock_i), .srst_i(srst_i), .bus_sample_clk_i(lclk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .analog_poweron_level_i(ana),
    .digital_poweron_level_i(dig), .temp_i(temp), .supply_low_i(vlow),
    .main_write_protect_i(wpm), .aux_write_protect_i(wpa), .standby_o(stby),
    .nv_busy_o(busy), .not_ready_flag_o(nrdy), .supply_low_alarm_o(alarm));
  smsp_master u_smsp_master (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  // system clock, and an unrelated 48 ns link clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = !clock_i;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = !lclk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the programming flag
  task automatic await_busy(input logic v, input int lim);
    for (int n = 0; n < lim && busy !== v; n++)
      @(negedge clock_i);
  endtask
  // address only; an empty write never programs, but wait out any programming already running
  task automatic probe(input logic [7:0] dev, output logic a);
    u_smsp_master.start();
    u_smsp_master.wbyte(dev, a);
    u_smsp_master.stop();
    repeat (30) @(negedge clock_i);
    await_busy(1'b0, NV_CYC + 100);
  endtask
  // write: bit k of acks is the answer to byte k
  task automatic wr(input logic [7:0] dev, input logic [7:0] loc, input logic [7:0] d [$],
                    input logic fin, output logic [7:0] acks);
    logic a;
    acks = '0;
    u_smsp_master.start();
    u_smsp_master.wbyte(dev, a);
    acks[0] = a;
    u_smsp_master.wbyte(loc, a);
    acks[1] = a;
    foreach (d[i])
    begin
      u_smsp_master.wbyte(d[i], a);
      acks[i + 2] = a;
    end
    if (fin)
      u_smsp_master.stop();
  endtask
  // random read: dummy write, repeated start, n bytes
  task automatic rd(input logic [7:0] dev, input logic [7:0] loc, input int n,
                    output logic [7:0] q [$]);
    logic       a;
    logic [7:0] b;
    q = {};
    u_smsp_master.start();
    u_smsp_master.wbyte(dev, a);
    u_smsp_master.wbyte(loc, a);
    u_smsp_master.start();
    u_smsp_master.wbyte(dev | 8'h01, a);
    for (int i = 0; i < n; i++)
    begin
      u_smsp_master.rbyte(i < n - 1, b);
      q.push_back(b);
    end
    u_smsp_master.stop();
  endtask
  // programming follows the stop and refuses a poll while it runs
  task automatic wait_prog();
    logic a;
    await_busy(1'b1, 100);
    check("programming", 8'h01, {7'h0, busy});
    probe(8'hA0, a);
    check("poll answer", 8'h00, {7'h0, a});
    check("programming done", 8'h00, {7'h0, busy});
  endtask
  task automatic t_reset();
    check("standby", 8'h01, {7'h0, stby});
    check("ready flag", 8'h01, {7'h0, nrdy});
    check("alarm flag", 8'h01, {7'h0, alarm});
  endtask
  // page write crossing the page end, then both reads
  task automatic t_page();
    logic [7:0] q [$];
    logic [7:0] k;
    wr(8'hA0, 8'h06, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, k);
    check("page acks", 8'h3F, k);
    wait_prog();
    rd(8'hA0, 8'h06, 3, q);
    check("loc 06", 8'h11, q[0]);
    check("loc 07", 8'h22, q[1]);
    check("loc 08", 8'hFF, q[2]);
    rd(8'hA0, 8'h00, 2, q);
    check("loc 00", 8'h33, q[0]);
    check("loc 01", 8'h44, q[1]);
  endtask
  // sequential read across the top of the window
  task automatic t_wrap();
    logic [7:0] q [$];
    logic [7:0] k;
    wr(8'hA0, 8'hFF, '{8'hC3, 8'h3C}, 1'b1, k);
    wait_prog();
    rd(8'hA0, 8'hFF, 2, q);
    check("loc FF", 8'hC3, q[0]);
    check("loc 00 after FF", 8'h33, q[1]);
    rd(8'hA0, 8'hF8, 1, q);
    check("loc F8", 8'h3C, q[0]);
  endtask
  // foreign address, lost page, protected window
  task automatic t_refuse();
    logic [7:0] q [$];
    logic [7:0] k;
    logic       a;
    probe(8'h52, a);
    check("foreign address", 8'h00, {7'h0, a});
    check("standby after", 8'h01, {7'h0, stby});
    wr(8'hA0, 8'h20, '{8'hAA}, 1'b0, k);
    rd(8'hA0, 8'h20, 1, q);
    repeat (30) @(negedge clock_i);
    check("no programming", 8'h00, {7'h0, busy});
    check("page dropped", 8'hFF, q[0]);
    wpa = 1'b1;
    wr(8'hA0, 8'h30, '{8'h5A}, 1'b1, k);
    repeat (30) @(negedge clock_i);
    check("protected acks", 8'h03, k);
    check("no programming", 8'h00, {7'h0, busy});
    wpa = 1'b0;
    rd(8'hA0, 8'h30, 1, q);
    check("protected loc", 8'hFF, q[0]);
    wpm = 1'b1;
    wr(8'hA2, 8'h31, '{8'hA5}, 1'b1, k);
    repeat (30) @(negedge clock_i);
    check("main protected acks", 8'h03, k);
    check("main no programming", 8'h00, {7'h0, busy});
    wpm = 1'b0;
  endtask
  // conversions, flags, configured address
  task automatic t_power();
    logic [7:0] q [$];
    logic [7:0] k;
    logic       a;
    ana = 1'b1;
    await_busy(1'b0, 1);
    for (int n = 0; n < 5 * FRM && nrdy !== 1'b0; n++)
      @(negedge clock_i);
    repeat (2 * FRM) @(negedge clock_i);
    check("ready flag", 8'h00, {7'h0, nrdy});
    check("alarm flag", 8'h00, {7'h0, alarm});
    rd(8'hA2, 8'h60, 2, q);
    check("temp msb", 8'h12, q[0]);
    check("temp lsb", 8'h34, q[1]);
    rd(8'hA2, 8'h6E, 3, q);
    check("ready bit", 8'h00, q[0] & 8'h01);
    check("alarm bit", 8'h00, q[2] & 8'h10);
    wr(8'hA2, 8'h8C, '{8'hB4}, 1'b1, k);
    wait_prog();
    probe(8'hA2, a);
    check("old address", 8'h00, {7'h0, a});
    probe(8'hB4, a);
    check("set address", 8'h01, {7'h0, a});
    ana = 1'b0;
    repeat (10) @(negedge clock_i);
    check("ready flag off", 8'h01, {7'h0, nrdy});
    probe(8'hB4, a);
    check("kept address", 8'h01, {7'h0, a});
  endtask
  // watchdog, well beyond the expected run
  initial
  begin
    repeat (90000) @(posedge clock_i);
    err_count++;
    $display("unexpected run length: expected end, seen hang");
    end_sim();
  end
  // reset for ten clocks; the link side takes it over through two flops
  initial
  begin
    srst_i = 1'b1;
    ana = 1'b0;
    dig = 1'b1;
    vlow = 1'b0;
    wpm = 1'b0;
    wpa = 1'b0;
    temp = 16'h1234;
    err_count = 0;
    checks = 0;
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (20) @(negedge clock_i);
    t_reset();
    t_page();
    t_wrap();
    t_refuse();
    t_power();
    end_sim();
  end
endmodule
`default_nettype wire
